// *** rtl/mctx_pkg.sv ***
// Purpose: Shared constants for the CSMA/CD transmitter.
// Assumes: Core clock of 100 MHz; link clock sampled as a plain input.
// Notes: Register offsets are word aligned byte addresses.
`default_nettype none
package mctx_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned PREAMBLE_BITS = 56;
    localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hd5;
    localparam int unsigned JAM_BITS = 32;
    localparam int unsigned IFG_BITS = 96;
    localparam int unsigned SLOT_BITS_DEF = 512;
    localparam logic [4:0] MAX_COLL = 5'h10;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] LFSR_SEED = 32'h1234abcd;
    localparam logic [31:0] LFSR_POLY = 32'h80200003;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_SLOT = 4'h8;
    localparam int unsigned CTRL_NIBBLE = 0;
    localparam int unsigned CTRL_NOCRC = 1;
    localparam logic [15:0] SLOT_RESET = 16'h0200;
    typedef enum logic [3:0] {
        MCTX_IDLE = 4'h0,
        MCTX_DEFER = 4'h1,
        MCTX_PRE = 4'h2,
        MCTX_DATA = 4'h3,
        MCTX_CRC = 4'h4,
        MCTX_JAM = 4'h5,
        MCTX_BACKOFF = 4'h6
    } mctx_state_t;
endpackage
`default_nettype wire

// *** rtl/mctx_top.sv ***
// Purpose: CSMA/CD frame transmitter toward an MII physical layer.
// Assumes: Link clock, carrier and collision come from the PHY domain.
// Notes: Frame bytes arrive on a valid/ready stream with a last marker.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`default_nettype none
module mctx_top
    import mctx_pkg::*;
#(
    parameter int unsigned GAP_WATCH_BITS = 64
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    input wire logic i_tx_last,
    input wire logic i_tx_nocrc,
    output logic o_tx_ready,
    input wire logic i_mii_tx_clk,
    input wire logic i_mii_crs,
    input wire logic i_mii_col,
    output logic [3:0] o_mii_txd,
    output logic o_mii_tx_en,
    output logic o_stat_valid,
    output logic o_stat_ok,
    output logic o_stat_underrun,
    output logic [4:0] o_stat_coll
);
    initial begin
        if (GAP_WATCH_BITS == 0 || GAP_WATCH_BITS >= IFG_BITS) begin
            $error("GAP_WATCH_BITS must lie inside the gap.");
        end
    end
    localparam logic [6:0] WATCH_END = 7'(GAP_WATCH_BITS);
    localparam logic [6:0] GAP_END = 7'(IFG_BITS);
    localparam logic [5:0] PRE_LAST = 6'(PREAMBLE_BITS / 8 - 1);
    localparam logic [5:0] PRE_END = 6'(PREAMBLE_BITS / 8);

    typedef struct packed {
        logic [2:0] s_clk;
        logic [1:0] s_crs;
        logic [1:0] s_col;
        mctx_state_t st;
        logic nibble;
        logic nocrc_cfg;
        logic [15:0] slot;
        logic [31:0] rdata;
        logic wait_n;
        logic [6:0] gap;
        logic [7:0] sh;
        logic [2:0] bitn;
        logic [5:0] cnt;
        logic [31:0] crc;
        logic nocrc;
        logic have_byte;
        logic last;
        logic [4:0] coll;
        logic [11:0] boff;
        logic [15:0] slotcnt;
        logic [31:0] lfsr;
        logic [3:0] txd;
        logic txen;
        logic sv;
        logic sok;
        logic sund;
        logic [4:0] scoll;
        logic rdy;
        logic was_coll;
        logic [7:0] hold;
        logic hold_last;
    } mctx_s_t;
    mctx_s_t s_reg;
    mctx_s_t s_next;

    function automatic logic [31:0] crc_bit(input logic [31:0] c,
                                            input logic b);
        crc_bit = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    endfunction

    logic tick;
    logic crs;
    logic col;
    logic [2:0] step;
    logic [31:0] crc_w;
    logic [3:0] out_w;
    logic [11:0] rmask;
    assign crs = s_reg.s_crs[1];
    assign col = s_reg.s_col[1];
    // Falling edge of the sampled link clock launches each symbol.
    assign tick = s_reg.s_clk[2] & ~s_reg.s_clk[1];
    assign step = s_reg.nibble ? 3'h4 : 3'h1;

    always_comb begin
        s_next = s_reg;
        crc_w = s_reg.crc;
        out_w = 4'h0;
        rmask = 12'h0;
        s_next.s_clk = {s_reg.s_clk[1:0], i_mii_tx_clk};
        s_next.s_crs = {s_reg.s_crs[0], i_mii_crs};
        s_next.s_col = {s_reg.s_col[0], i_mii_col};
        s_next.sv = 1'b0;
        s_next.rdy = 1'b0;
        s_next.wait_n = 1'b0;
        s_next.lfsr = s_reg.lfsr[0] ? ((s_reg.lfsr >> 1) ^ LFSR_POLY)
                                    : (s_reg.lfsr >> 1);
        if ((i_avs_read || i_avs_write) && !s_reg.wait_n) begin
            s_next.wait_n = 1'b1;
            s_next.rdata = 32'h0;
            unique case (i_avs_address)
                ADDR_CTRL: s_next.rdata = {30'h0, s_reg.nocrc_cfg,
                                           s_reg.nibble};
                ADDR_STAT: s_next.rdata = {21'h0, s_reg.st, s_reg.sund,
                                           s_reg.sok, s_reg.scoll[4:0]};
                ADDR_SLOT: s_next.rdata = {16'h0, s_reg.slot};
                default: s_next.rdata = 32'h0;
            endcase
        end
        // Writes land at the edge that accepts them.
        if (i_avs_write && s_reg.wait_n) begin
            if (i_avs_address == ADDR_CTRL) begin
                s_next.nibble = i_avs_writedata[CTRL_NIBBLE];
                s_next.nocrc_cfg = i_avs_writedata[CTRL_NOCRC];
            end
            // Slot length in bit times is software set.
            if (i_avs_address == ADDR_SLOT
                && i_avs_writedata[15:0] != 16'h0) begin
                s_next.slot = i_avs_writedata[15:0];
            end
        end
        if (tick) begin
            unique case (s_reg.st)
                MCTX_IDLE, MCTX_DEFER: begin
                    s_next.txen = 1'b0;
                    // Deference counts only once line is quiet.
                    if (s_reg.gap < WATCH_END && (crs || col)) begin
                        s_next.gap = 7'h0;
                    end else if (s_reg.gap < GAP_END) begin
                        // Second part ignores activity.
                        s_next.gap = s_reg.gap + 7'(step);
                    end
                    s_next.st = MCTX_DEFER;
                    // Start only after the full gap.
                    if (s_reg.gap >= GAP_END && i_tx_valid) begin
                        s_next.st = MCTX_PRE;
                        s_next.cnt = 6'h0;
                        s_next.bitn = 3'h0;
                        s_next.sh = PREAMBLE_BYTE;
                        s_next.crc = CRC_INIT;
                        s_next.was_coll = 1'b0;
                        s_next.nocrc = i_tx_nocrc | s_reg.nocrc_cfg;
                        s_next.sund = 1'b0;
                        s_next.have_byte = 1'b0;
                    end
                end
                MCTX_PRE, MCTX_DATA: begin
                    // Low bits first for both widths.
                    out_w = s_reg.nibble ? s_reg.sh[3:0]
                                         : {3'h0, s_reg.sh[0]};
                    s_next.txd = out_w;
                    s_next.txen = 1'b1;
                    if (s_reg.st == MCTX_DATA && !s_reg.nocrc) begin
                        for (int i = 0; i < 4; i++) begin
                            if (i < int'(step)) begin
                                crc_w = crc_bit(crc_w, out_w[i]);
                            end
                        end
                        s_next.crc = crc_w;
                    end
                    if (col) begin
                        s_next.was_coll = 1'b1;
                    end
                    s_next.sh = s_reg.sh >> step;
                    s_next.bitn = s_reg.bitn + step;
                    if (3'(s_reg.bitn + step) == 3'h0) begin
                        s_next.cnt = s_reg.cnt + 6'h1;
                        if (s_reg.st == MCTX_PRE && s_reg.cnt != PRE_END) begin
                            s_next.sh = (s_reg.cnt == PRE_LAST)
                                        ? SFD_BYTE : PREAMBLE_BYTE;
                            // First byte is asked for under the delimiter.
                            // Bytes fetched before a collision are not kept.
                            s_next.rdy = (s_reg.cnt == PRE_LAST)
                                         && !(s_reg.was_coll | col);
                        end else if (s_reg.was_coll | col) begin
                            // Preamble finishes even on collision.
                            s_next.st = MCTX_JAM;
                            s_next.cnt = 6'h0;
                        end else if (s_reg.st == MCTX_DATA && s_reg.last) begin
                            s_next.st = s_reg.nocrc ? MCTX_DEFER : MCTX_CRC;
                            s_next.cnt = 6'h0;
                            s_next.sh = 8'h0;
                            if (s_reg.nocrc) begin
                                // Frame sent without check field.
                                s_next.sv = 1'b1;
                                s_next.sok = 1'b1;
                                s_next.sund = 1'b0;
                                s_next.scoll = s_reg.coll;
                                s_next.coll = 5'h0;
                                s_next.gap = 7'h0;
                            end
                        end else if (!s_reg.have_byte) begin
                            // No byte ready when needed.
                            s_next.st = MCTX_JAM;
                            s_next.cnt = 6'h0;
                            s_next.sund = 1'b1;
                        end else begin
                            s_next.st = MCTX_DATA;
                            s_next.sh = s_reg.hold;
                            s_next.last = s_reg.hold_last;
                            s_next.rdy = !s_reg.hold_last;
                            s_next.have_byte = 1'b0;
                        end
                    end
                end
                MCTX_CRC: begin
                    // Reflected register: bit zero holds the top term.
                    for (int i = 0; i < 4; i++) begin
                        out_w[i] = ~s_reg.crc[i];
                    end
                    s_next.txd = s_reg.nibble ? out_w : {3'h0, out_w[0]};
                    s_next.crc = s_reg.crc >> step;
                    s_next.cnt = s_reg.cnt + 6'(step);
                    if (s_reg.cnt + 6'(step) == 6'd32) begin
                        s_next.st = MCTX_DEFER;
                        s_next.sv = 1'b1;
                        s_next.sok = 1'b1;
                        s_next.sund = 1'b0;
                        s_next.scoll = s_reg.coll;
                        s_next.coll = 5'h0;
                        s_next.gap = 7'h0;
                    end
                end
                MCTX_JAM: begin
                    s_next.txd = s_reg.nibble ? 4'hf : 4'h1;
                    s_next.cnt = s_reg.cnt + 6'(step);
                    if (s_reg.cnt + 6'(step) == 6'(JAM_BITS)) begin
                        // Every attempt reports status.
                        s_next.sv = 1'b1;
                        s_next.sok = 1'b0;
                        s_next.scoll = s_reg.coll + 5'(!s_reg.sund);
                        s_next.coll = s_reg.coll + 5'h1;
                        s_next.gap = 7'h0;
                        if (s_reg.sund || s_reg.coll + 5'h1 == MAX_COLL) begin
                            s_next.st = MCTX_DEFER;
                            s_next.coll = 5'h0;
                        end else begin
                            for (int i = 0; i < 12; i++) begin
                                rmask[i] = (5'(i) < s_reg.coll);
                            end
                            s_next.boff = s_reg.lfsr[11:0] & rmask;
                            s_next.slotcnt = 16'h0;
                            s_next.st = MCTX_BACKOFF;
                        end
                    end
                end
                MCTX_BACKOFF: begin
                    s_next.txen = 1'b0;
                    s_next.slotcnt = s_reg.slotcnt + 16'(step);
                    if (s_reg.boff == 12'h0) begin
                        s_next.st = MCTX_DEFER;
                    end else if (s_reg.slotcnt + 16'(step) >= s_reg.slot) begin
                        s_next.slotcnt = 16'h0;
                        s_next.boff = s_reg.boff - 12'h1;
                    end
                end
                default: s_next.st = MCTX_IDLE;
            endcase
        end
        if (s_reg.rdy && i_tx_valid) begin
            s_next.have_byte = 1'b1;
            s_next.hold = i_tx_data;
            s_next.hold_last = i_tx_last;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_reg <= '0;
            s_reg.slot <= SLOT_RESET;
            s_reg.lfsr <= LFSR_SEED;
            s_reg.st <= MCTX_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_avs_readdata = s_reg.rdata;
    assign o_avs_waitrequest = !s_reg.wait_n;
    assign o_tx_ready = s_reg.rdy;
    assign o_mii_txd = s_reg.txd;
    assign o_mii_tx_en = s_reg.txen;
    assign o_stat_valid = s_reg.sv;
    assign o_stat_ok = s_reg.sok;
    assign o_stat_underrun = s_reg.sund;
    assign o_stat_coll = s_reg.scoll;

    property p_jam_len;
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(s_reg.st == MCTX_JAM) |-> s_reg.cnt == 6'h0;
    endproperty
    a_jam_len: assert property (p_jam_len) else $error("Jam count bad.");
    property p_no_start_in_gap;
        @(posedge i_clk) disable iff (!i_rstn)
        (s_reg.st == MCTX_DEFER && s_next.st == MCTX_PRE)
            |-> s_reg.gap >= GAP_END;
    endproperty
    a_no_start_in_gap: assert property (p_no_start_in_gap)
        else $error("Start during gap.");
    property p_watch_reset;
        @(posedge i_clk) disable iff (!i_rstn)
        (tick && s_reg.st == MCTX_DEFER && s_reg.gap < WATCH_END && crs)
            |=> s_reg.gap == 7'h0;
    endproperty
    a_watch_reset: assert property (p_watch_reset)
        else $error("Gap not cleared.");
    property p_commit;
        @(posedge i_clk) disable iff (!i_rstn)
        (tick && s_reg.st == MCTX_DEFER && s_reg.gap >= WATCH_END
            && s_reg.gap < GAP_END) |=> s_reg.gap != 7'h0;
    endproperty
    a_commit: assert property (p_commit) else $error("Gap reset late.");
    property p_coll_max;
        @(posedge i_clk) disable iff (!i_rstn)
        o_stat_valid |-> o_stat_coll <= MAX_COLL;
    endproperty
    a_coll_max: assert property (p_coll_max) else $error("Count over 16.");
    property p_ok_status;
        @(posedge i_clk) disable iff (!i_rstn)
        (o_stat_valid && o_stat_ok) |-> !o_stat_underrun;
    endproperty
    a_ok_status: assert property (p_ok_status)
        else $error("Good status with underrun.");
    property p_backoff_bound;
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(s_reg.st == MCTX_BACKOFF) |-> (s_reg.boff >> s_reg.coll) == 0
            || s_reg.coll >= 5'd12;
    endproperty
    a_backoff_bound: assert property (p_backoff_bound)
        else $error("Backoff out of range.");
    property p_txen_idle;
        @(posedge i_clk) disable iff (!i_rstn)
        (s_reg.st == MCTX_BACKOFF && tick) |=> !o_mii_tx_en;
    endproperty
    a_txen_idle: assert property (p_txen_idle)
        else $error("Driving in backoff.");
    c_ok: cover property (@(posedge i_clk) o_stat_valid && o_stat_ok);
    c_coll: cover property (@(posedge i_clk) s_reg.st == MCTX_BACKOFF);
    c_abort: cover property (@(posedge i_clk) o_stat_coll == MAX_COLL);
endmodule // mctx_top
`default_nettype wire

// *** test/mctx_phy_model.sv ***
// Purpose: MII physical layer model facing the frame transmitter.
// Assumes: Transmit clock runs free with a 160 ns period.
// Notes: Carrier follows own transmit enable or a forced level.
`default_nettype none
module mctx_phy_model (
    input wire logic [3:0] i_txd,
    input wire logic i_tx_en,
    input wire logic i_nibble,
    input wire logic i_crs_force,
    input wire logic i_col_req,
    output logic o_tx_clk,
    output logic o_crs,
    output logic o_col,
    output logic [7:0] o_byte,
    output logic o_byte_stb,
    output logic [31:0] o_tail
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh;
    int nbit;
    int nbyte;
    initial begin
        o_tx_clk = 1'b0;
        o_col = 1'b0;
        o_byte = 8'h00;
        o_byte_stb = 1'b0;
        o_tail = 32'h0;
        sh = 8'h00;
    end
    always #80 o_tx_clk = ~o_tx_clk;
    assign o_crs = i_tx_en | i_crs_force;
    always @(posedge o_tx_clk) begin
        o_byte_stb <= 1'b0;
        if (i_tx_en !== 1'b1) begin
            nbit = 0;
            nbyte = 0;
            o_col <= 1'b0;
        end else begin
            sh = i_nibble ? {i_txd, sh[7:4]} : {i_txd[0], sh[7:1]};
            o_tail <= i_nibble ? {i_txd, o_tail[31:4]} :
                {i_txd[0], o_tail[31:1]};
            nbit = nbit + (i_nibble ? 4 : 1);
            if (nbit == 8) begin
                nbit = 0;
                nbyte++;
                o_byte <= sh;
                o_byte_stb <= 1'b1;
            end
            if (i_col_req && nbyte >= 3) begin
                o_col <= 1'b1;
            end
        end
    end
endmodule // mctx_phy_model
`default_nettype wire

// *** test/test_mii_csmacd_transmitter.sv ***
// Purpose: Self-checking bench for the CSMA/CD frame transmitter.
// Assumes: The PHY model supplies transmit clock, carrier and collision.
// Notes: Frames are compared byte by byte as seen on the MII lines.
`default_nettype none
module test_mii_csmacd_transmitter import mctx_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0, i_rstn = 1'b0;
    logic [3:0] i_avs_address = 4'h0;
    logic i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
    logic o_avs_waitrequest, o_tx_ready, o_mii_tx_en;
    logic [7:0] i_tx_data = 8'h00;
    logic i_tx_valid = 1'b0, i_tx_last = 1'b0, i_tx_nocrc = 1'b0;
    logic i_mii_tx_clk, i_mii_crs, i_mii_col;
    logic [3:0] o_mii_txd;
    logic o_stat_valid, o_stat_ok, o_stat_underrun;
    logic [4:0] o_stat_coll;
    logic nibble = 1'b0, crs_force = 1'b0, col_req = 1'b0;
    logic [7:0] phy_byte;
    logic phy_stb;
    logic [31:0] phy_tail, last_tail;
    logic [7:0] rx_q[$], last_frame[$];
    logic [6:0] stat_q[$];
    int failures = 0, cmp_count = 0, frame_cnt = 0;
    realtime t_rise, t_fall, t_drop;
    mctx_top #(.GAP_WATCH_BITS(64)) uut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_tx_data(i_tx_data),
        .i_tx_valid(i_tx_valid), .i_tx_last(i_tx_last),
        .i_tx_nocrc(i_tx_nocrc), .o_tx_ready(o_tx_ready),
        .i_mii_tx_clk(i_mii_tx_clk), .i_mii_crs(i_mii_crs),
        .i_mii_col(i_mii_col), .o_mii_txd(o_mii_txd),
        .o_mii_tx_en(o_mii_tx_en), .o_stat_valid(o_stat_valid),
        .o_stat_ok(o_stat_ok), .o_stat_underrun(o_stat_underrun),
        .o_stat_coll(o_stat_coll));
    mctx_phy_model phy (.i_txd(o_mii_txd), .i_tx_en(o_mii_tx_en),
        .i_nibble(nibble), .i_crs_force(crs_force), .i_col_req(col_req),
        .o_tx_clk(i_mii_tx_clk), .o_crs(i_mii_crs), .o_col(i_mii_col),
        .o_byte(phy_byte), .o_byte_stb(phy_stb), .o_tail(phy_tail));
    always #5 i_clk = ~i_clk;
    always @(negedge i_mii_tx_clk) begin
        if (phy_stb === 1'b1) rx_q.push_back(phy_byte);
    end
    always @(posedge o_mii_tx_en) t_rise = $realtime;
    always @(negedge o_mii_tx_en) begin
        last_frame = rx_q;
        rx_q = {};
        last_tail = phy_tail;
        t_fall = $realtime;
        frame_cnt++;
    end
    always @(posedge i_clk) begin
        if (o_stat_valid === 1'b1) begin
            stat_q.push_back({o_stat_underrun, o_stat_ok, o_stat_coll});
        end
    end
    task automatic stop_test();
        $display("compared %0d, failed %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic hang(input string nm);
        failures++;
        $display("CHECK FAILED %s expected done seen timeout", nm);
        stop_test();
    endtask
    task automatic av(input logic [3:0] a, input logic wr,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        i_avs_writedata <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 100);
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        if (n >= 100) hang("avalon");
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(a, 1'b1, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a,
                          input logic [31:0] e);
        logic [31:0] q;
        av(a, 1'b0, 32'h0, q);
        check(nm, q, e);
    endtask
    task automatic send(input logic [7:0] b[$], input logic nocrc,
                        input logic cut);
        int n;
        i_tx_nocrc <= nocrc;
        foreach (b[i]) begin
            i_tx_data <= b[i];
            i_tx_valid <= 1'b1;
            i_tx_last <= (i == b.size() - 1) && !cut;
            n = 0;
            do begin
                @(posedge i_clk);
                n++;
            end while (o_tx_ready !== 1'b1 && n < 5000);
            if (n >= 5000) hang("tx ready");
        end
        i_tx_valid <= 1'b0;
        i_tx_last <= 1'b0;
    endtask
    task automatic wait_done(input int frames);
        int n;
        n = 0;
        while ((frame_cnt < frames || stat_q.size() == 0) && n < 20000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 20000) hang("frame end");
    endtask
    task automatic stat_chk(input logic [6:0] exp, input logic [6:0] mask);
        logic [6:0] s;
        s = stat_q.pop_front();
        check("status", {25'h0, s & mask}, {25'h0, exp});
    endtask
    task automatic frame_chk(input logic [7:0] b[$], input logic nocrc);
        logic [7:0] e[$];
        logic [31:0] c;
        e = {};
        repeat (7) e.push_back(PREAMBLE_BYTE);
        e.push_back(SFD_BYTE);
        c = CRC_INIT;
        foreach (b[i]) begin
            e.push_back(b[i]);
            c = c ^ {24'h0, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        c = ~c;
        for (int i = 0; i < 4; i++) begin
            if (!nocrc) e.push_back(c[8*i +: 8]);
        end
        check("frame length", last_frame.size(), e.size());
        foreach (e[i]) check("frame byte", last_frame[i], e[i]);
    endtask
    initial begin
        logic [7:0] frm[$] = '{8'h01, 8'h23, 8'hc4, 8'hf0, 8'h7e};
        int f0;
        int nn;
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd_chk("ctrl reset", ADDR_CTRL, 32'h0);
        rd_chk("slot reset", ADDR_SLOT, {16'h0, SLOT_RESET});
        rd_chk("unmapped", 4'hc, 32'h0);
        wr(ADDR_SLOT, 32'h0);
        rd_chk("slot zero", ADDR_SLOT, {16'h0, SLOT_RESET});
        wr(ADDR_SLOT, 32'h40);
        rd_chk("slot set", ADDR_SLOT, 32'h40);
        wr(ADDR_CTRL, 32'h1);
        nibble <= 1'b1;
        rd_chk("ctrl set", ADDR_CTRL, 32'h1);
        $display("registers done");
        f0 = frame_cnt;
        send(frm, 1'b0, 1'b0);
        wait_done(f0 + 1);
        frame_chk(frm, 1'b0);
        stat_chk(7'h20, 7'h7f);
        rd_chk("status reg", ADDR_STAT, {21'h0, MCTX_DEFER, 7'h20});
        f0 = frame_cnt;
        send(frm, 1'b1, 1'b0);
        wait_done(f0 + 1);
        frame_chk(frm, 1'b1);
        stat_chk(7'h20, 7'h7f);
        $display("nibble frames done");
        wr(ADDR_CTRL, 32'h2);
        nibble <= 1'b0;
        f0 = frame_cnt;
        send(frm, 1'b0, 1'b0);
        wait_done(f0 + 1);
        frame_chk(frm, 1'b1);
        stat_chk(7'h20, 7'h7f);
        wr(ADDR_CTRL, 32'h1);
        nibble <= 1'b1;
        $display("serial frame done");
        col_req <= 1'b1;
        f0 = frame_cnt;
        fork
            send(frm, 1'b0, 1'b0);
            begin
                nn = 0;
                while (i_mii_col !== 1'b1 && nn < 5000) begin
                    @(posedge i_clk);
                    nn++;
                end
                col_req <= 1'b0;
            end
        join
        wait_done(f0 + 1);
        check("jam tail", last_tail, 32'hffffffff);
        check("preamble end", {24'h0, last_frame[6]}, 32'h55);
        stat_chk(7'h01, 7'h7f);
        wait_done(f0 + 2);
        frame_chk(frm, 1'b0);
        stat_chk(7'h21, 7'h7f);
        $display("collision done");
        crs_force <= 1'b1;
        f0 = frame_cnt;
        fork
            send(frm, 1'b0, 1'b0);
            begin
                repeat (800) @(posedge i_clk);
                check("held", {31'h0, o_mii_tx_en}, 32'h0);
                crs_force <= 1'b0;
                t_drop = $realtime;
            end
        join
        wait_done(f0 + 1);
        check("gap", {31'h0, t_rise - t_drop >= 3680.0 &&
            t_rise - t_drop <= 4800.0}, 32'h1);
        stat_chk(7'h20, 7'h7f);
        fork
            send(frm, 1'b0, 1'b0);
            begin
                repeat (320) @(posedge i_clk);
                crs_force <= 1'b1;
            end
        join
        check("commit", {31'h0, t_rise - t_fall <= 4800.0}, 32'h1);
        crs_force <= 1'b0;
        wait_done(f0 + 2);
        stat_chk(7'h20, 7'h7f);
        $display("deference done");
        f0 = frame_cnt;
        send(frm[0:1], 1'b0, 1'b1);
        wait_done(f0 + 1);
        stat_chk(7'h40, 7'h7f);
        $display("underrun done");
        stop_test();
    end
endmodule // test_mii_csmacd_transmitter
`default_nettype wire
